// File: slfc_pkg.sv
// Constants and types shared by the store-to-load forwarding check.
// Assumes one core clock and a synchronous active-high reset.
package slfc_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int SLFC_AW = 32;
    localparam int SLFC_DW = 128;
    localparam int SLFC_ENTRIES = 8;
    localparam int SLFC_IDX_W = 3;
    localparam int SLFC_PRED_ENTRIES = 16;
    localparam int SLFC_PRED_W = 4;
    // ------------------------------------------------------------
    // Access width codes
    // ------------------------------------------------------------
    localparam logic [2:0] SLFC_W8 = 3'h0;
    localparam logic [2:0] SLFC_W16 = 3'h1;
    localparam logic [2:0] SLFC_W32 = 3'h2;
    localparam logic [2:0] SLFC_W64 = 3'h3;
    localparam logic [2:0] SLFC_W128 = 3'h4;
    // Unaligned store start offsets that the table names
    localparam logic [3:0] SLFC_UNAL_B1 = 4'h1;
    localparam logic [3:0] SLFC_UNAL_B7 = 4'h7;
    // Recovery penalty after a mispredicted early issue
    localparam int SLFC_PENALTY_NS = 50;
    localparam int SLFC_CLK_NS = 10;
    localparam int SLFC_PENALTY_CYC = (SLFC_PENALTY_NS + SLFC_CLK_NS - 1) / SLFC_CLK_NS;
    localparam logic [3:0] SLFC_PRED_RST = 4'h0;

    typedef enum logic [1:0] {SLFC_FWD, SLFC_STALL, SLFC_WAIT, SLFC_MEM} slfc_dec_e;
endpackage : slfc_pkg

// File: slfc_rule.sv
// Size and alignment check for one store against one load.
// Pure combinational; the caller has already found an overlap.
module slfc_rule
    import slfc_pkg::*;
(
    input wire logic [SLFC_AW-1:0] st_addr,
    input wire logic [2:0] st_w,
    input wire logic [SLFC_AW-1:0] ld_addr,
    input wire logic [2:0] ld_w,
    output logic fwd_ok
);
    logic [7:0] st_n, ld_n;
    logic [SLFC_AW-1:0] off;
    logic st_nat, contained;
    always_comb begin
        st_n = 8'h1 << st_w;
        ld_n = 8'h1 << ld_w;
        off = ld_addr - st_addr;
        st_nat = (st_addr & (SLFC_AW'(st_n) - 1)) == '0;
        contained = (ld_addr >= st_addr) && (off + SLFC_AW'(ld_n) <= SLFC_AW'(st_n));
        fwd_ok = 1'b0;
        if (contained) begin
            if (st_nat && st_w != SLFC_W8) begin
                if (off == '0) begin
                    fwd_ok = 1'b1;
                end else begin
                    case (ld_w)
                        SLFC_W16: fwd_ok = (st_w == SLFC_W32) && !off[0];
                        SLFC_W32: fwd_ok = (st_w >= SLFC_W64) && off[1:0] == 2'h0;
                        SLFC_W64: fwd_ok = (st_w == SLFC_W128) && off[2:0] == 3'h0;
                        default: fwd_ok = 1'b0;
                    endcase
                end
            end else if (st_addr[3:0] == SLFC_UNAL_B1 || st_addr[3:0] == 4'h9) begin
                fwd_ok = (off == '0) && (ld_w <= SLFC_W32);
            end else if (st_addr[2:0] == SLFC_UNAL_B7[2:0]) begin
                fwd_ok = (ld_w == SLFC_W8) && (st_w == SLFC_W32);
            end else begin
                fwd_ok = (off == '0) && st_w == ld_w;
            end
        end
    end
endmodule // slfc_rule

// File: slfc_check.sv
// Store buffer forwarding check: records older stores, decides per load.
// Assumes the load pipeline holds a stalled load and replays on done.
// Operation
// - Wide load over several narrow older stores stalls until they write.
// - Stalled wide load gets data only from memory, never merged.
// - Narrow load at disallowed offset in wide store stalls until write.
// - Aligned store not at byte 7 forwards contained load at its start; 16 at even of 32.
// - 32 at dword of 64 or 128, 64 at qword of 128 forward; others stall.
// - Store at byte 1 forwards 8/16/32 at its start only.
// - Store at byte 7 forwards only bytes of a 32-bit store.
// - Dependent load completes only once store data is available.
// - Predict dependent loads and schedule them after their store.
// - Early issue recovers with a penalty, never wrong data.
// - Store writes to memory only after retirement; forwarding continues.
// - Forwarding needs the load wholly inside one older store.
// - Waiting loads do not block unrelated or younger loads; during a recovery penalty every load gets WAIT.
module slfc_check
    import slfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic st_alloc,
    input wire logic [SLFC_AW-1:0] st_addr,
    input wire logic [2:0] st_w,
    input wire logic st_data_vld,
    input wire logic [SLFC_IDX_W-1:0] st_data_idx,
    input wire logic [SLFC_DW-1:0] st_data,
    input wire logic st_retire,
    input wire logic mem_wr_ack,
    input wire logic ld_req,
    input wire logic [SLFC_AW-1:0] ld_addr,
    input wire logic [2:0] ld_w,
    input wire logic [SLFC_AW-1:0] ld_pc,
    output logic st_full,
    output logic mem_wr_req,
    output logic [SLFC_AW-1:0] mem_wr_addr,
    output logic [2:0] mem_wr_w,
    output logic [SLFC_DW-1:0] mem_wr_data,
    output logic ld_resp_vld,
    output slfc_dec_e ld_dec,
    output logic [SLFC_DW-1:0] ld_fwd_data,
    output logic ld_pred_dep,
    output logic ld_replay,
    output logic ld_recover
);
    // ------------------------------------------------------------
    // Store buffer, circular, oldest at head
    // ------------------------------------------------------------
    logic [SLFC_AW-1:0] sb_addr_r [SLFC_ENTRIES];
    logic [2:0] sb_w_r [SLFC_ENTRIES];
    logic [SLFC_DW-1:0] sb_data_r [SLFC_ENTRIES];
    logic [SLFC_ENTRIES-1:0] sb_vld_r, sb_dv_r, sb_ret_r;
    logic [SLFC_IDX_W-1:0] head_r, tail_r, ret_r;
    logic [SLFC_IDX_W:0] cnt_r;
    logic wr_busy_r;

    function automatic logic [SLFC_AW-1:0] end_of(input logic [SLFC_AW-1:0] a,
                                                 input logic [2:0] w);
        end_of = a + (SLFC_AW'(1) << w) - SLFC_AW'(1);
    endfunction

    // Only the bytes the load asked for; the store may be wider
    function automatic logic [SLFC_DW-1:0] ld_mask(input logic [2:0] w);
        ld_mask = ~({SLFC_DW{1'b1}} << (9'h8 << w));
    endfunction

    logic [SLFC_ENTRIES-1:0] ovl, fok;
    genvar g;
    generate
        for (g = 0; g < SLFC_ENTRIES; g++) begin : g_cmp
            assign ovl[g] = sb_vld_r[g] && !(end_of(sb_addr_r[g], sb_w_r[g]) < ld_addr
                || end_of(ld_addr, ld_w) < sb_addr_r[g]);
            slfc_rule u_rule (
                .st_addr(sb_addr_r[g]),
                .st_w(sb_w_r[g]),
                .ld_addr(ld_addr),
                .ld_w(ld_w),
                .fwd_ok(fok[g])
            );
        end
    endgenerate

    // Youngest older overlapping store, count of overlaps
    logic hit;
    logic [SLFC_IDX_W-1:0] hit_idx, idx;
    logic [SLFC_IDX_W:0] n_ovl;
    always_comb begin
        hit = 1'b0;
        hit_idx = '0;
        n_ovl = '0;
        idx = '0;
        for (int i = 0; i < SLFC_ENTRIES; i++) begin
            idx = head_r + SLFC_IDX_W'(i);
            if (ovl[idx]) begin
                hit = 1'b1;
                hit_idx = idx;
                n_ovl = n_ovl + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Dependence predictor, indexed by load pc
    // ------------------------------------------------------------
    logic [SLFC_PRED_ENTRIES-1:0] pred_r;
    logic [SLFC_PRED_W-1:0] pidx;
    logic [3:0] pen_r;
    assign pidx = ld_pc[SLFC_PRED_W+1:2];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pred_r <= '0;
        end else if (ld_req && pen_r == '0) begin
            pred_r[pidx] <= hit;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pen_r <= SLFC_PRED_RST;
        end else if (pen_r != '0) begin
            pen_r <= pen_r - 4'h1;
        end else if (ld_req && hit && !pred_r[pidx] && !sb_dv_r[hit_idx]) begin
            pen_r <= 4'(SLFC_PENALTY_CYC);
        end
    end

    // ------------------------------------------------------------
    // Load decision, one per request, no queue so others pass except while pen_r counts down
    // ------------------------------------------------------------
    slfc_dec_e dec_nxt;
    always_comb begin
        if (pen_r != '0) begin
            dec_nxt = SLFC_WAIT;
        end else if (!hit) begin
            dec_nxt = SLFC_MEM;
        end else if (n_ovl > 1) begin
            dec_nxt = SLFC_STALL;
        end else if (!fok[hit_idx]) begin
            dec_nxt = SLFC_STALL;
        end else if (!sb_dv_r[hit_idx]) begin
            dec_nxt = SLFC_WAIT;
        end else begin
            dec_nxt = SLFC_FWD;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ld_resp_vld <= 1'b0;
            ld_dec <= SLFC_MEM;
            ld_fwd_data <= '0;
            ld_pred_dep <= 1'b0;
            ld_recover <= 1'b0;
        end else begin
            ld_resp_vld <= ld_req;
            ld_dec <= dec_nxt;
            ld_fwd_data <= (dec_nxt == SLFC_FWD)
                ? (sb_data_r[hit_idx] >> {4'(ld_addr - sb_addr_r[hit_idx]), 3'h0})
                  & ld_mask(ld_w) : '0;
            ld_pred_dep <= ld_req && pred_r[pidx];
            ld_recover <= ld_req && pen_r == '0 && hit && !pred_r[pidx]
                && !sb_dv_r[hit_idx];
        end
    end

    // ------------------------------------------------------------
    // Store allocation, data, retirement and drain
    // ------------------------------------------------------------
    logic drain;
    assign drain = wr_busy_r && mem_wr_ack;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sb_vld_r <= '0;
            sb_dv_r <= '0;
            sb_ret_r <= '0;
            tail_r <= '0;
            head_r <= '0;
            ret_r <= '0;
            cnt_r <= '0;
        end else begin
            if (st_alloc && !st_full) begin
                sb_vld_r[tail_r] <= 1'b1;
                sb_dv_r[tail_r] <= 1'b0;
                sb_ret_r[tail_r] <= 1'b0;
                sb_addr_r[tail_r] <= st_addr;
                sb_w_r[tail_r] <= st_w;
                tail_r <= tail_r + 1'b1;
            end
            if (st_data_vld) begin
                sb_dv_r[st_data_idx] <= 1'b1;
                sb_data_r[st_data_idx] <= st_data;
            end
            if (st_retire && sb_vld_r[ret_r] && !sb_ret_r[ret_r]) begin
                sb_ret_r[ret_r] <= 1'b1;
                ret_r <= ret_r + 1'b1;
            end
            if (drain) begin
                sb_vld_r[head_r] <= 1'b0;
                head_r <= head_r + 1'b1;
            end
            cnt_r <= cnt_r + (SLFC_IDX_W+1)'(st_alloc && !st_full) - (SLFC_IDX_W+1)'(drain);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_full <= 1'b0;
        end else begin
            st_full <= (cnt_r + (SLFC_IDX_W+1)'(st_alloc && !st_full)
                - (SLFC_IDX_W+1)'(drain)) >= (SLFC_IDX_W+1)'(SLFC_ENTRIES - 1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_busy_r <= 1'b0;
            mem_wr_req <= 1'b0;
            mem_wr_addr <= '0;
            mem_wr_w <= SLFC_W8;
            mem_wr_data <= '0;
            ld_replay <= 1'b0;
        end else begin
            ld_replay <= drain;
            if (drain) begin
                wr_busy_r <= 1'b0;
                mem_wr_req <= 1'b0;
            end else if (!wr_busy_r && sb_vld_r[head_r] && sb_ret_r[head_r]
                         && sb_dv_r[head_r]) begin
                wr_busy_r <= 1'b1;
                mem_wr_req <= 1'b1;
                mem_wr_addr <= sb_addr_r[head_r];
                mem_wr_w <= sb_w_r[head_r];
                mem_wr_data <= sb_data_r[head_r];
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_drain;
        wr_busy_r && mem_wr_ack;
    endsequence

    multi_stall_a: assert property (@(posedge sys_clk) disable iff (rst)
        ld_req && pen_r == '0 && n_ovl > 1 |=> ld_dec == SLFC_STALL)
        else $error("multi store overlap forwarded");
    no_merge_a: assert property (@(posedge sys_clk) disable iff (rst)
        ld_resp_vld && ld_dec != SLFC_FWD |-> ld_fwd_data == '0)
        else $error("data on non forward answer");
    bad_off_a: assert property (@(posedge sys_clk) disable iff (rst)
        ld_req && pen_r == '0 && hit && !fok[hit_idx] |=> ld_dec == SLFC_STALL)
        else $error("disallowed offset not stalled");
    fwd_table_a: assert property (@(posedge sys_clk) disable iff (rst)
        ld_resp_vld && ld_dec == SLFC_FWD |-> $past(fok[hit_idx]) && $past(n_ovl) == 1)
        else $error("forward outside table");
    data_avail_a: assert property (@(posedge sys_clk) disable iff (rst)
        ld_req && hit && !sb_dv_r[hit_idx] |=> ld_dec != SLFC_FWD)
        else $error("forward before data");
    recover_pen_a: assert property (@(posedge sys_clk) disable iff (rst)
        ld_recover |-> (pen_r != '0)[*5])
        else $error("penalty too short");
    retire_wr_a: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(mem_wr_req) |-> $past(sb_ret_r[head_r]))
        else $error("write before retire");
    replay_a: assert property (@(posedge sys_clk) disable iff (rst)
        s_drain |=> ld_replay ##1 !ld_replay)
        else $error("replay not pulsed");
    pass_a: assert property (@(posedge sys_clk) disable iff (rst)
        ld_req |=> ld_resp_vld)
        else $error("load not answered");
endmodule // slfc_check

// File: slfc_mem_model.sv
// Memory side of the load/store pipeline: takes store writes, counts replays.
// Assumes one core clock; lat sets the cycles before each write is acked.
module slfc_mem_model
    import slfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] lat,
    input wire logic mem_wr_req,
    input wire logic [SLFC_AW-1:0] mem_wr_addr,
    input wire logic ld_replay,
    output logic mem_wr_ack,
    output logic [SLFC_AW-1:0] last_addr,
    output int wr_cnt,
    output int replay_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;
    // ------------------------------------------------------------
    // Write acceptance, prompt or slow
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_wr_ack <= 1'b0;
            cnt_r <= 4'h0;
            wr_cnt <= 0;
            last_addr <= '0;
        end else if (mem_wr_ack) begin
            mem_wr_ack <= 1'b0;
        end else if (mem_wr_req) begin
            if (cnt_r >= lat) begin
                mem_wr_ack <= 1'b1;
                cnt_r <= 4'h0;
                wr_cnt <= wr_cnt + 1;
                last_addr <= mem_wr_addr;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
    // Replay notices from the check are counted here, one per pulse
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            replay_cnt <= 0;
        end else if (ld_replay) begin
            replay_cnt <= replay_cnt + 1;
        end
    end
endmodule // slfc_mem_model

// File: slfc_check_bench.sv
// Self-checking bench for the store-to-load forwarding check.
// Assumes a 100 MHz core clock and the memory model on the write side.
module slfc_check_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import slfc_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, st_alloc = 1'b0, st_data_vld = 1'b0, st_retire = 1'b0;
    logic ld_req = 1'b0, st_full, mem_wr_req, mem_wr_ack, ld_resp_vld, ld_pred_dep;
    logic ld_replay, ld_recover;
    logic [SLFC_AW-1:0] st_addr = '0, ld_addr = '0, ld_pc = '0, mem_wr_addr, last_addr;
    logic [2:0] st_w = 3'h0, ld_w = 3'h0, mem_wr_w;
    logic [SLFC_IDX_W-1:0] st_data_idx = '0, tail;
    logic [SLFC_DW-1:0] st_data = '0, mem_wr_data, ld_fwd_data;
    logic [3:0] lat = 4'h1;
    slfc_dec_e ld_dec;
    int wr_cnt, replay_cnt, bad_count = 0, comparisons = 0;
    localparam logic [SLFC_DW-1:0] PAT = 128'hF0E1D2C3B4A5968778695A4B3C2D1E0F;
    slfc_check uut (.sys_clk(sys_clk), .rst(rst), .st_alloc(st_alloc), .st_addr(st_addr),
        .st_w(st_w), .st_data_vld(st_data_vld), .st_data_idx(st_data_idx), .st_data(st_data),
        .st_retire(st_retire), .mem_wr_ack(mem_wr_ack), .ld_req(ld_req), .ld_addr(ld_addr),
        .ld_w(ld_w), .ld_pc(ld_pc), .st_full(st_full), .mem_wr_req(mem_wr_req),
        .mem_wr_addr(mem_wr_addr), .mem_wr_w(mem_wr_w), .mem_wr_data(mem_wr_data),
        .ld_resp_vld(ld_resp_vld), .ld_dec(ld_dec), .ld_fwd_data(ld_fwd_data),
        .ld_pred_dep(ld_pred_dep), .ld_replay(ld_replay), .ld_recover(ld_recover));
    slfc_mem_model mem (.sys_clk(sys_clk), .rst(rst), .lat(lat), .mem_wr_req(mem_wr_req),
        .mem_wr_addr(mem_wr_addr), .ld_replay(ld_replay), .mem_wr_ack(mem_wr_ack),
        .last_addr(last_addr), .wr_cnt(wr_cnt), .replay_cnt(replay_cnt));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [SLFC_DW-1:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    function automatic logic [SLFC_DW-1:0] wmask(input logic [2:0] w);
        return (w == SLFC_W128) ? '1 : ((128'h1 << (8 << w)) - 128'h1);
    endfunction
    task automatic do_reset();
        @(posedge sys_clk) rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        tail = '0;
    endtask
    // Data may arrive later than the allocation; with_data=0 leaves it missing
    task automatic store(input logic [31:0] a, input logic [2:0] w, input bit with_data);
        @(posedge sys_clk) st_alloc <= 1'b1;
        st_addr <= a;
        st_w <= w;
        @(posedge sys_clk) st_alloc <= 1'b0;
        st_data_vld <= with_data;
        st_data_idx <= tail;
        st_data <= PAT & wmask(w);
        tail = tail + 1'b1;
        @(posedge sys_clk) st_data_vld <= 1'b0;
    endtask
    task automatic load(input logic [31:0] a, input logic [2:0] w, input logic [31:0] pc,
                        input slfc_dec_e d, input logic [SLFC_DW-1:0] data);
        @(posedge sys_clk) ld_req <= 1'b1;
        ld_addr <= a;
        ld_w <= w;
        ld_pc <= pc;
        @(posedge sys_clk) ld_req <= 1'b0;
        #1;
        chk("ld_resp_vld", 128'(ld_resp_vld), 128'h1);
        chk("ld_dec", 128'(ld_dec), 128'(d));
        chk("ld_fwd_data", ld_fwd_data, data);
    endtask
    task automatic retire_one();
        @(posedge sys_clk) st_retire <= 1'b1;
        @(posedge sys_clk) st_retire <= 1'b0;
    endtask
    task automatic wait_writes(input int n);
        for (int i = 0; i < 60 && wr_cnt < n; i++) @(posedge sys_clk);
        chk("wr_cnt", 128'(wr_cnt), 128'(n));
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic table_case(input logic [31:0] sa, input logic [2:0] sw,
                              input logic [31:0] la, input logic [2:0] lw, input slfc_dec_e d);
        logic [SLFC_DW-1:0] e;
        do_reset();
        e = (d == SLFC_FWD) ? ((PAT & wmask(sw)) >> (8 * (la - sa))) & wmask(lw) : '0;
        store(sa, sw, 1'b1);
        load(la, lw, 32'h0, d, e);
    endtask
    task automatic sc_wide_over_narrow();
        do_reset();
        lat <= 4'h4;
        store(32'h100, SLFC_W32, 1'b1);
        store(32'h104, SLFC_W32, 1'b1);
        load(32'h100, SLFC_W64, 32'h4, SLFC_STALL, '0);
        load(32'h104, SLFC_W32, 32'h8, SLFC_FWD, PAT & wmask(SLFC_W32));
        chk("mem_wr_req", 128'(mem_wr_req), 128'h0);
        retire_one();
        wait_writes(1);
        chk("last_addr", 128'(last_addr), 128'h100);
        chk("mem_wr_w", 128'(mem_wr_w), 128'(SLFC_W32));
        chk("mem_wr_data", mem_wr_data, PAT & wmask(SLFC_W32));
        retire_one();
        wait_writes(2);
        chk("last_addr", 128'(last_addr), 128'h104);
        repeat (3) @(posedge sys_clk);
        chk("replay_cnt", 128'(replay_cnt), 128'h2);
        load(32'h100, SLFC_W64, 32'h4, SLFC_MEM, '0);
    endtask
    task automatic sc_late_data();
        logic seen_rec;
        do_reset();
        lat <= 4'h0;
        store(32'h300, SLFC_W32, 1'b0);
        load(32'h300, SLFC_W32, 32'h40, SLFC_WAIT, '0);
        seen_rec = ld_recover;
        @(posedge sys_clk) #1 seen_rec = seen_rec | ld_recover;
        chk("ld_recover", 128'(seen_rec), 128'h1);
        repeat (SLFC_PENALTY_CYC + 2) @(posedge sys_clk);
        @(posedge sys_clk) st_data_vld <= 1'b1;
        st_data_idx <= '0;
        st_data <= PAT & wmask(SLFC_W32);
        @(posedge sys_clk) st_data_vld <= 1'b0;
        load(32'h300, SLFC_W32, 32'h40, SLFC_FWD, PAT & wmask(SLFC_W32));
        load(32'h300, SLFC_W8, 32'h40, SLFC_FWD, PAT & wmask(SLFC_W8));
        chk("ld_pred_dep", 128'(ld_pred_dep), 128'h1);
        load(32'h500, SLFC_W32, 32'h80, SLFC_MEM, '0);
    endtask
    // Seven stores fill the buffer; an eighth allocation must be refused
    task automatic sc_fill();
        do_reset();
        for (int i = 0; i < 7; i++) begin
            store(32'h400 + 32'(i * 16), SLFC_W32, 1'b1);
            if (i == 5) begin
                chk("st_full", 128'(st_full), 128'h0);
            end
        end
        chk("st_full", 128'(st_full), 128'h1);
        @(posedge sys_clk) st_alloc <= 1'b1;
        st_addr <= 32'h800;
        st_w <= SLFC_W32;
        @(posedge sys_clk) st_alloc <= 1'b0;
        load(32'h800, SLFC_W32, 32'hC, SLFC_MEM, '0);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200us;
        bad_count++;
        print_verdict();
    end
    initial begin
        do_reset();
        #1;
        chk("ld_dec reset", 128'(ld_dec), 128'(SLFC_MEM));
        chk("mem_wr_req reset", 128'(mem_wr_req), 128'h0);
        table_case(32'h100, SLFC_W16, 32'h100, SLFC_W16, SLFC_FWD);
        table_case(32'h100, SLFC_W32, 32'h100, SLFC_W8, SLFC_FWD);
        table_case(32'h100, SLFC_W32, 32'h102, SLFC_W16, SLFC_FWD);
        table_case(32'h100, SLFC_W32, 32'h101, SLFC_W8, SLFC_STALL);
        table_case(32'h100, SLFC_W32, 32'h101, SLFC_W16, SLFC_STALL);
        table_case(32'h100, SLFC_W32, 32'h102, SLFC_W32, SLFC_STALL);
        table_case(32'h100, SLFC_W64, 32'h104, SLFC_W32, SLFC_FWD);
        table_case(32'h100, SLFC_W64, 32'h102, SLFC_W16, SLFC_STALL);
        table_case(32'h100, SLFC_W128, 32'h108, SLFC_W64, SLFC_FWD);
        table_case(32'h100, SLFC_W128, 32'h104, SLFC_W32, SLFC_FWD);
        table_case(32'h100, SLFC_W128, 32'h104, SLFC_W64, SLFC_STALL);
        table_case(32'h100, SLFC_W128, 32'h100, SLFC_W128, SLFC_FWD);
        table_case(32'h101, SLFC_W32, 32'h101, SLFC_W32, SLFC_FWD);
        table_case(32'h101, SLFC_W64, 32'h103, SLFC_W8, SLFC_STALL);
        table_case(32'h101, SLFC_W64, 32'h101, SLFC_W64, SLFC_STALL);
        table_case(32'h107, SLFC_W32, 32'h109, SLFC_W8, SLFC_FWD);
        table_case(32'h107, SLFC_W32, 32'h107, SLFC_W16, SLFC_STALL);
        table_case(32'h107, SLFC_W64, 32'h107, SLFC_W32, SLFC_STALL);
        table_case(32'h100, SLFC_W32, 32'h200, SLFC_W32, SLFC_MEM);
        sc_wide_over_narrow();
        sc_late_data();
        sc_fill();
        print_verdict();
    end
endmodule // slfc_check_bench
